/* hw/scm_pkg.sv */
// Constants, types and field layout of the supply control monitor.
// Assumes the 100 MHz system clock; used by scm_top and scm_spi_link.
// Overview of operation
// - Main regulator on in request/normal/standby/reset
// - Main undervoltage holds reset output 1ms
// - Main undervoltage sets reset status flag
// - 145C warning sets flag, maskable interrupt
// - 175C shut-off flags, interrupts, disables main
// - Main regulator returns when below warning
// - Main off in sleep, emergency, no battery
// - Peripheral regulator on only normal, not shut
// - Peripheral undervoltage sets supply status flag
// - 140C peripheral warning flags, maskable interrupt
// - 165C peripheral shut-off latched until host restart
// - Peripheral off outside normal or main off
// - Battery switch per config; off in request
// - Sleep battery switch follows cyclic sense
// - Switch overheat flags, off, auto returns
// - Switch off if main off outside sleep, peripheral shut
// - Battery below 4V flags and interrupts
// - Battery above 20V flags, interrupts, nothing else
// - Start in request state after power-up

package scm_pkg;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_KHZ        = 100000;
    localparam int RESET_MS       = 1;
    localparam int RESET_CYCLES   = RESET_MS * CLK_KHZ;
    localparam int CYC_ON_MS      = 1;
    localparam int CYC_OFF_MS     = 32;
    localparam int CYC_ON_CYCLES  = CYC_ON_MS * CLK_KHZ;
    localparam int CYC_OFF_CYCLES = CYC_OFF_MS * CLK_KHZ;
    localparam int CNT_W          = 24;

    // ************************************************
    // Serial frame layout
    // ************************************************
    localparam int FRAME_W      = 16;
    localparam int F_MODE_LSB   = 13;
    localparam int F_V3_NORMAL  = 12;
    localparam int F_V3_STANDBY = 11;
    localparam int F_V3_CYCLIC  = 10;
    localparam int F_V2_RESTART = 9;
    localparam int F_MASK_LSB   = 4;
    localparam int F_CAN_LSB    = 2;
    localparam int MASK_W       = 5;

    localparam logic [2:0] CMD_KEEP    = 3'h0;
    localparam logic [2:0] CMD_NORMAL  = 3'h1;
    localparam logic [2:0] CMD_STANDBY = 3'h2;
    localparam logic [2:0] CMD_SLEEP   = 3'h3;
    localparam logic [2:0] CMD_EMERG   = 3'h4;

    localparam logic [MASK_W-1:0] MASK_RESET = 5'h1F;
    localparam logic [1:0]        CAN_RESET  = 2'h0;

    typedef enum logic [2:0] {
        MODE_NREQ, MODE_NORMAL, MODE_STANDBY, MODE_SLEEP, MODE_EMERG
    } scm_mode_t;

    typedef struct packed {
        logic v1Uv;
        logic v1Warn;
        logic v1Shut;
        logic v2Uv;
        logic v2Warn;
        logic v2Shut;
        logic v3Hot;
        logic batLow;
        logic battery_high_flag;
        logic batAbsent;
    } scm_det_t;

    typedef struct packed {
        logic resetUv;
        logic otV1Warn;
        logic otV1Shut;
        logic otV2Warn;
        logic otV2Shut;
        logic supV2Uv;
        logic supV3Hot;
        logic supBatLow;
        logic supBatHigh;
    } scm_flags_t;

endpackage

/* hw/scm_spi_link.sv */
// Serial link shifter, running on the host's serial clock.
// Assumes the clock only moves while chip select is low, 16 edges a frame.
`timescale 1ns/1ps

module scm_spi_link (
    input  wire logic                        sclk,
    input  wire logic                        csN,
    input  wire logic                        mosi,
    input  wire logic [scm_pkg::FRAME_W-1:0] txWord,
    output logic                             miso,
    output logic      [scm_pkg::FRAME_W-1:0] rxWord
);

    logic [3:0]                  bitCnt;
    logic [scm_pkg::FRAME_W-1:0] shiftIn;

    // ************************************************
    // Bit counter, cleared by the frame's own select
    // ************************************************
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            bitCnt <= 4'h0;
        end else begin
            bitCnt <= bitCnt + 4'h1;
        end
    end

    // Input sampled on the falling edge
    always_ff @(negedge sclk) begin
        shiftIn <= {shiftIn[scm_pkg::FRAME_W-2:0], mosi};
        if (bitCnt == 4'hF) begin
            rxWord <= {shiftIn[scm_pkg::FRAME_W-2:0], mosi};
        end
    end

    // Output launched on the rising edge; status word is held still during frames
    always_ff @(posedge sclk) begin
        miso <= txWord[~bitCnt];
    end

endmodule

/* hw/scm_top.sv */
// Supply enables, reset pulse, status flags and interrupt of the supply monitor.
// Assumes detector levels are asynchronous pins and the host drives a 16-bit serial link.
`timescale 1ns/1ps

module scm_top #(
    parameter int RST_CYCLES = scm_pkg::RESET_CYCLES,
    parameter int CYC_ON     = scm_pkg::CYC_ON_CYCLES,
    parameter int CYC_OFF    = scm_pkg::CYC_OFF_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire scm_pkg::scm_det_t detPins,
    input  wire logic              sclk,
    input  wire logic              csN,
    input  wire logic              mosi,
    output logic                   miso,
    output logic                   misoEn,
    output logic                   v1En,
    output logic                   v2En,
    output logic                   v3En,
    output logic                   rstOutN,
    output logic                   intN,
    output logic [1:0]             canMode,
    output scm_pkg::scm_mode_t     mode
);

    scm_pkg::scm_det_t            detS1;
    scm_pkg::scm_det_t            det;
    scm_pkg::scm_flags_t          flags;
    scm_pkg::scm_flags_t          next_flags;
    scm_pkg::scm_flags_t          intMask;
    logic [2:0]                   csSync;
    logic                         frameEnd;
    logic [scm_pkg::FRAME_W-1:0]  rxWord;
    logic [scm_pkg::FRAME_W-1:0]  txWord;
    logic [scm_pkg::MASK_W-1:0]   mask;
    logic                         v3Normal;
    logic                         v3Standby;
    logic                         v3Cyclic;
    logic                         v1Hot;
    logic                         v2Shut;
    logic                         v3Hot;
    logic [16:0]                  rstCnt;
    logic                         rstActive;
    logic [scm_pkg::CNT_W-1:0]    cycCnt;
    logic                         cycPhase;
    logic                         next_v1;
    logic                         next_v2;
    logic                         next_v3;

    // ************************************************
    // Link and synchronisers
    // ************************************************
    scm_spi_link link (
        .sclk   (sclk),
        .csN    (csN),
        .mosi   (mosi),
        .txWord (txWord),
        .miso   (miso),
        .rxWord (rxWord)
    );

    always_ff @(posedge mclk) begin
        detS1  <= detPins;
        det    <= detS1;
        csSync <= {csSync[1:0], csN};
    end

    // Word from the link is stable once select is back high; no sclk edges follow
    assign frameEnd = csSync[1] & ~csSync[2];

    always_ff @(posedge mclk) begin
        if (rst) begin
            misoEn <= 1'b0;
        end else begin
            misoEn <= ~csSync[1];
        end
    end

    // Snapshot only changes between frames, so the shifter sees a steady word
    always_ff @(posedge mclk) begin
        if (rst) begin
            txWord <= '0;
        end else if (csSync[1]) begin
            txWord <= {mode, flags, 4'h0};
        end
    end

    function automatic scm_pkg::scm_mode_t modeDecode(input logic [2:0] cmd,
                                                      input scm_pkg::scm_mode_t cur);
        if (cmd == scm_pkg::CMD_NORMAL) begin
            modeDecode = scm_pkg::MODE_NORMAL;
        end else if (cmd == scm_pkg::CMD_STANDBY) begin
            modeDecode = scm_pkg::MODE_STANDBY;
        end else if (cmd == scm_pkg::CMD_SLEEP) begin
            modeDecode = scm_pkg::MODE_SLEEP;
        end else if (cmd == scm_pkg::CMD_EMERG) begin
            modeDecode = scm_pkg::MODE_EMERG;
        end else begin
            modeDecode = cur;
        end
    endfunction

    // ************************************************
    // Configuration from the host
    // ************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode <= scm_pkg::MODE_NREQ;
        end else if (frameEnd) begin
            mode <= modeDecode(rxWord[scm_pkg::F_MODE_LSB +: 3], mode);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mask      <= scm_pkg::MASK_RESET;
            canMode   <= scm_pkg::CAN_RESET;
            v3Normal  <= 1'b0;
            v3Standby <= 1'b0;
            v3Cyclic  <= 1'b0;
        end else if (frameEnd) begin
            mask      <= rxWord[scm_pkg::F_MASK_LSB +: scm_pkg::MASK_W];
            canMode   <= rxWord[scm_pkg::F_CAN_LSB +: 2];
            v3Normal  <= rxWord[scm_pkg::F_V3_NORMAL];
            v3Standby <= rxWord[scm_pkg::F_V3_STANDBY];
            v3Cyclic  <= rxWord[scm_pkg::F_V3_CYCLIC];
        end
    end

    // ************************************************
    // Thermal latches
    // ************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            v1Hot <= 1'b0;
        end else if (det.v1Shut) begin
            v1Hot <= 1'b1;
        end else if (!det.v1Warn) begin
            v1Hot <= 1'b0;
        end
    end

    // Stays off until the host asks again and the die has cooled
    always_ff @(posedge mclk) begin
        if (rst) begin
            v2Shut <= 1'b0;
        end else if (det.v2Shut) begin
            v2Shut <= 1'b1;
        end else if (frameEnd && rxWord[scm_pkg::F_V2_RESTART]) begin
            v2Shut <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            v3Hot <= 1'b0;
        end else begin
            v3Hot <= det.v3Hot;
        end
    end

    // ************************************************
    // Reset pulse
    // ************************************************
    always_ff @(posedge mclk) begin
        if (rst || det.v1Uv) begin
            rstCnt <= 17'(RST_CYCLES);
        end else if (rstCnt != 17'h0) begin
            rstCnt <= rstCnt - 17'h1;
        end
    end

    assign rstActive = (rstCnt != 17'h0);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rstOutN <= 1'b0;
        end else begin
            rstOutN <= ~rstActive;
        end
    end

    // ************************************************
    // Cyclic sense timer
    // ************************************************
    always_ff @(posedge mclk) begin
        if (rst || mode != scm_pkg::MODE_SLEEP) begin
            cycCnt   <= '0;
            cycPhase <= 1'b1;
        end else if (cycPhase && cycCnt == scm_pkg::CNT_W'(CYC_ON - 1)) begin
            cycCnt   <= '0;
            cycPhase <= 1'b0;
        end else if (!cycPhase && cycCnt == scm_pkg::CNT_W'(CYC_OFF - 1)) begin
            cycCnt   <= '0;
            cycPhase <= 1'b1;
        end else begin
            cycCnt <= cycCnt + 1'b1;
        end
    end

    // ************************************************
    // Supply enables
    // ************************************************
    always_comb begin
        next_v1 = (mode == scm_pkg::MODE_NREQ || mode == scm_pkg::MODE_NORMAL ||
                   mode == scm_pkg::MODE_STANDBY || rstActive);
        if (mode == scm_pkg::MODE_SLEEP || mode == scm_pkg::MODE_EMERG ||
            det.batAbsent || v1Hot) begin
            next_v1 = 1'b0;
        end
        next_v2 = (mode == scm_pkg::MODE_NORMAL) && !v2Shut && next_v1;
        case (mode)
            scm_pkg::MODE_NORMAL:  next_v3 = v3Normal;
            scm_pkg::MODE_STANDBY: next_v3 = v3Standby;
            scm_pkg::MODE_SLEEP:   next_v3 = v3Cyclic && cycPhase && !det.batAbsent;
            default:               next_v3 = 1'b0;
        endcase
        // Sleep drops the main supply by design, so only other causes count there
        if (v3Hot || v2Shut || (!next_v1 && mode != scm_pkg::MODE_SLEEP)) begin
            next_v3 = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            v1En <= 1'b0;
            v2En <= 1'b0;
            v3En <= 1'b0;
        end else begin
            v1En <= next_v1;
            v2En <= next_v2;
            v3En <= next_v3;
        end
    end

    // ************************************************
    // Status flags and interrupt
    // ************************************************
    always_comb begin
        next_flags = frameEnd ? '0 : flags;
        // Set wins over the clear of a read frame
        if (det.v1Uv)    next_flags.resetUv    = 1'b1;
        if (det.v1Warn)  next_flags.otV1Warn   = 1'b1;
        if (det.v1Shut)  next_flags.otV1Shut   = 1'b1;
        if (det.v2Warn)  next_flags.otV2Warn   = 1'b1;
        if (det.v2Shut)  next_flags.otV2Shut   = 1'b1;
        if (det.v2Uv)    next_flags.supV2Uv    = 1'b1;
        if (det.v3Hot)   next_flags.supV3Hot   = 1'b1;
        if (det.batLow)  next_flags.supBatLow  = 1'b1;
        if (det.battery_high_flag) next_flags.supBatHigh = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    assign intMask = {1'b0, ~mask[4], ~mask[3], ~mask[2], 3'h0, ~mask[1], ~mask[0]};

    always_ff @(posedge mclk) begin
        if (rst) begin
            intN <= 1'b1;
        end else begin
            intN <= ~|(next_flags & intMask);
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    // Latch, then enable flop: the regulator drops two edges after the detector
    a_v1_off_shut: assert property (@(posedge mclk) disable iff (rst)
        det.v1Shut |-> ##2 !v1En) else $error("main regulator on during shut-off");
    a_v1_mode_on: assert property (@(posedge mclk) disable iff (rst)
        (mode == scm_pkg::MODE_STANDBY && !det.batAbsent && !v1Hot) |=> v1En)
        else $error("main regulator off in standby");
    a_v1_sleep_off: assert property (@(posedge mclk) disable iff (rst)
        (mode == scm_pkg::MODE_SLEEP || mode == scm_pkg::MODE_EMERG) |=> !v1En)
        else $error("main regulator on in sleep");
    a_v2_normal_only: assert property (@(posedge mclk) disable iff (rst)
        v2En |-> $past(mode) == scm_pkg::MODE_NORMAL && $past(v1Hot) == 1'b0)
        else $error("peripheral regulator on outside normal");
    a_v2_latched_off: assert property (@(posedge mclk) disable iff (rst)
        (v2Shut && !frameEnd) |=> v2Shut) else $error("shut-off latch dropped");
    a_v2_shut_off: assert property (@(posedge mclk) disable iff (rst)
        v2Shut |=> (!v2En && !v3En)) else $error("supply on during peripheral shut-off");
    a_rst_pulse: assert property (@(posedge mclk) disable iff (rst)
        $fell(det.v1Uv) |-> ##1 !rstOutN [*8]) else $error("reset pulse too short");
    a_v3_request_off: assert property (@(posedge mclk) disable iff (rst)
        (mode == scm_pkg::MODE_NREQ) |=> !v3En) else $error("switch on in request");
    a_v3_hot_off: assert property (@(posedge mclk) disable iff (rst)
        v3Hot |=> !v3En) else $error("switch on while hot");
    a_bat_low_int: assert property (@(posedge mclk) disable iff (rst)
        (det.batLow && !mask[1]) |=> !intN) else $error("battery low no interrupt");
    a_masked_quiet: assert property (@(posedge mclk) disable iff (rst)
        (mask == 5'h1F) |=> intN) else $error("masked source raised interrupt");
    a_uv_flag: assert property (@(posedge mclk) disable iff (rst)
        det.v1Uv |=> flags.resetUv) else $error("undervoltage flag not set");

endmodule

/* tb/scm_host_model.sv */
// Host side of the supply monitor's serial link: one 16-bit frame per call.
// Assumes the bench waits for each frame to end; the link clock stands still between frames.
`timescale 1ns/1ps

module scm_host_model (
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    // ************************************************
    // Frame engine
    // ************************************************
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b1;
    end

    // Mode command, transceiver mode and peripheral restart all travel in wr
    task automatic frame(input logic [15:0] wr, output logic [15:0] rd);
        logic [15:0] sh;
        // Odd start offset keeps the 48 ns link clock unrelated to mclk
        #7;
        sh   = wr;
        csN  = 1'b0;
        mosi = sh[15];
        for (int i = 0; i < 16; i++) begin
            #20 sclk = 1'b1;
            #24 rd = {rd[14:0], miso};
            sclk = 1'b0;
            sh = {sh[14:0], ~wr[0]};
            // Data moves well after the falling edge, so the sample never races it
            #4 mosi = sh[15];
        end
        #20 csN = 1'b1;
    endtask
endmodule

/* tb/supply_control_monitor_tb.sv */
// Self-checking bench for scm_top with a behavioural model of modes and enables.
// Assumes scm_pkg and scm_host_model; short parameters keep the run small.
`timescale 1ns/1ps

module supply_control_monitor_tb;
    localparam int RST_C = 20;
    logic              mclk = 1'b0;
    logic              rst  = 1'b1;
    scm_pkg::scm_det_t det  = '0;
    logic              sclk, csN, mosi, miso, misoEn, v1En, v2En, v3En, rstOutN, intN;
    logic [1:0]        canMode;
    scm_pkg::scm_mode_t mode;
    logic [31:0]       seed = 32'h7DC9;
    int                fails = 0;
    int                checks = 0;
    logic [2:0]        modeN = 3'h0;
    logic              v3N = 1'b1, v3S = 1'b0, cyc = 1'b0, rs2 = 1'b0, v2Lat = 1'b0;
    logic [4:0]        msk = 5'h1F;
    logic [1:0]        can = 2'h0;
    logic [15:0]       rd;
    logic [31:0]       r;
    int                ones;

    always #5 mclk = ~mclk;

    scm_top #(.RST_CYCLES(RST_C), .CYC_ON(10), .CYC_OFF(30)) i_scm_top (
        .mclk(mclk), .rst(rst), .detPins(det), .sclk(sclk), .csN(csN), .mosi(mosi),
        .miso(miso), .misoEn(misoEn), .v1En(v1En), .v2En(v2En), .v3En(v3En),
        .rstOutN(rstOutN), .intN(intN), .canMode(canMode), .mode(mode));

    scm_host_model i_scm_host_model (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ticks(int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic test_done();
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Write a command, then settle the model the same way the device should
    task automatic send(logic [2:0] cmd);
        fork
            i_scm_host_model.frame({cmd, v3N, v3S, cyc, rs2, msk, can, 2'h0}, rd);
            begin
                ticks(20);
                chk("misoEn", {15'h0, misoEn}, 16'h0001);
            end
        join
        ticks(8);
        chk("misoEn idle", {15'h0, misoEn}, 16'h0000);
        if (cmd != 3'h0)
            modeN = cmd;
        if (rs2 && !det.v2Shut)
            v2Lat = 1'b0;
    endtask

    // Enables as the model predicts them; sleep switch phase is checked apart
    task automatic chk_out();
        logic e1, e2, e3;
        e1 = !(modeN == 3'h3 || modeN == 3'h4) && !det.v1Shut && !det.batAbsent;
        e2 = (modeN == 3'h1) && e1 && !v2Lat;
        e3 = e1 && !v2Lat && !det.v3Hot && ((modeN == 3'h1 && v3N) || (modeN == 3'h2 && v3S));
        chk("v1En", {15'h0, v1En}, {15'h0, e1});
        chk("v2En", {15'h0, v2En}, {15'h0, e2});
        if (modeN != 3'h3)
            chk("v3En", {15'h0, v3En}, {15'h0, e3});
        chk("mode", {13'h0, mode}, {13'h0, modeN});
    endtask

    // Read-word flag position of each detector pin
    function automatic logic [8:0] flagOf(int d);
        case (d)
            9: return 9'h100;
            8: return 9'h080;
            7: return 9'h040;
            6: return 9'h008;
            5: return 9'h020;
            4: return 9'h010;
            3: return 9'h004;
            2: return 9'h002;
            1: return 9'h001;
            default: return 9'h000;
        endcase
    endfunction

    function automatic int src(int d);
        case (d)
            8: return 4;
            7: return 3;
            5: return 2;
            2: return 1;
            1: return 0;
            default: return -1;
        endcase
    endfunction

    // ************************************************
    // Detector event: pulse, observe, read and clear
    // ************************************************
    task automatic det_case(int d);
        logic ie;
        ie = !(src(d) >= 0 && !msk[src(d)]);
        @(posedge mclk);
        det[d] <= 1'b1;
        if (d == 4)
            v2Lat = 1'b1;
        ticks(6);
        chk_out();
        chk("intN", {15'h0, intN}, {15'h0, ie});
        if (d == 9)
            chk("rstOutN", {15'h0, rstOutN}, 16'h0000);
        det[d] <= 1'b0;
        ticks(6);
        chk_out();
        if (d == 9) begin
            chk("rstOutN", {15'h0, rstOutN}, 16'h0000);
            ticks(RST_C);
            chk("rstOutN", {15'h0, rstOutN}, 16'h0001);
        end
        send(3'h0);
        chk("status", rd, {modeN, flagOf(d), 4'h0});
        chk("intN", {15'h0, intN}, 16'h0001);
        chk_out();
        if (d == 4) begin
            rs2 = 1'b1;
            send(3'h0);
            rs2 = 1'b0;
            chk_out();
        end
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        ticks(8);
        rst <= 1'b0;
        ticks(3);
        chk_out();
        chk("rstOutN", {15'h0, rstOutN}, 16'h0000);
        ticks(RST_C + 2);
        chk("rstOutN", {15'h0, rstOutN}, 16'h0001);
        send(3'h1);
        chk("status mode", {13'h0, rd[15:13]}, 16'h0000);
        // Random mode, switch and transceiver settings
        for (int i = 0; i < 8; i++) begin
            r   = rnd();
            v3N = r[1];
            v3S = r[2];
            can = r[4:3];
            send(r[0] ? 3'h2 : 3'h1);
            chk("canMode", {14'h0, canMode}, {14'h0, can});
            chk_out();
        end
        v3N = 1'b1;
        for (int k = 0; k < 2; k++) begin
            msk = k ? 5'h00 : 5'h1F;
            send(3'h1);
            for (int d = 9; d >= 0; d--)
                det_case(d);
        end
        // Sleep: switch follows 10 on, 30 off; two whole periods give 20 on cycles
        for (int k = 1; k >= 0; k--) begin
            cyc = k[0];
            send(3'h3);
            chk_out();
            ones = 0;
            repeat (80) begin
                @(posedge mclk);
                ones += v3En;
            end
            chk("cyclic on", 16'(ones), k ? 16'h0014 : 16'h0000);
        end
        send(3'h4);
        chk_out();
        test_done();
    end

    initial begin
        #500000;
        fails++;
        test_done();
    end
endmodule
